// [core/icc_map.svh]
// Register offsets, field positions, reset values and limits of the controller config block.
// Assumes inclusion by bare name from the matcher, top module and bench of this block.
`ifndef ICC_MAP_SVH
`define ICC_MAP_SVH

`define ICC_OFF_CON 8'h00
`define ICC_OFF_SAR 8'h08
`define ICC_OFF_MCMD 8'h10
`define ICC_OFF_RAW 8'h34
`define ICC_OFF_CLR_ABRT 8'h54
`define ICC_OFF_CLR_STOP 8'h60
`define ICC_OFF_ENABLE 8'h6C

`define ICC_CON_MASTER 0
`define ICC_CON_SPD_LO 1
`define ICC_CON_SPD_HI 2
`define ICC_CON_TWIDE 3
`define ICC_CON_CWIDE 4
`define ICC_CON_RESTART 5
`define ICC_CON_TOFF 6
`define ICC_CON_STOPADDR 7
`define ICC_CON_TXEC 8
`define ICC_CON_RXHOLD 9
`define ICC_CON_MSTOP 10
`define ICC_CON_RST 32'h0000_0065
`define ICC_CON_WMASK 32'h0000_03FF

`define ICC_SAR_RST 10'h055
`define ICC_TOP_RATE 2'h2
`define ICC_SPD_STD 2'h1

`define ICC_RAW_ABRT 6
`define ICC_RAW_STOP 9

`define ICC_CMD_RD 0
`define ICC_CMD_SBYTE 1
`define ICC_CMD_HS 2
`define ICC_CMD_DIRCHG 3

`define ICC_GCALL 8'h00
`define ICC_WIDE_PFX 5'h1E

`endif

// [core/icc_pkg.sv]
// Types shared by the controller config block.
// Assumes icc_map.svh is on the include path.
package icc_pkg;
  typedef struct packed {
    logic start;
    logic stop;
    logic byte_vld;
    logic first;
    logic [7:0] byte_val;
  } icc_evt_t;

  typedef struct packed {
    logic rxhold;
    logic txec;
    logic stopaddr;
    logic toff;
    logic restart;
    logic cwide;
    logic twide;
    logic [1:0] speed;
    logic master;
  } icc_cfg_t;

  typedef enum logic [1:0] {
    ICC_M_IDLE = 2'b00,
    ICC_M_WAIT2 = 2'b01,
    ICC_M_HIT = 2'b10,
    ICC_M_SKIP = 2'b11
  } icc_mst_t;
endpackage : icc_pkg

// [core/icc_watch.sv]
// Two-wire line watcher: synchronises the clock and data lines, finds START, STOP and bytes.
// Assumes lines arrive asynchronously; runs on the processor bus clock.
`timescale 1ns/1ps
module icc_watch (
  input wire logic CLK, // Bus clock
  input wire logic RST, // Sync reset, high
  input wire logic scl_i, // Raw clock line
  input wire logic sda_i, // Raw data line
  output icc_pkg::icc_evt_t evt // Line events, one-cycle pulses
);
  import icc_pkg::*;
  logic [1:0] scl_s_r;
  logic [1:0] sda_s_r;
  logic scl_d_r;
  logic sda_d_r;
  logic [7:0] sh_r;
  logic [3:0] cnt_r;
  logic first_r;
  logic scl_rise;

  // --------------------------------
  // Synchronisers, second stage feeds all logic
  // --------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      scl_s_r <= 2'h3;
      sda_s_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_s_r <= {scl_s_r[0], scl_i};
      sda_s_r <= {sda_s_r[0], sda_i};
      scl_d_r <= scl_s_r[1];
      sda_d_r <= sda_s_r[1];
    end
  end

  assign scl_rise = scl_s_r[1] & ~scl_d_r;

  // --------------------------------
  // Byte shifter; ninth clock is the acknowledge slot
  // --------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      evt <= '0;
      sh_r <= 8'h00;
      cnt_r <= 4'h0;
      first_r <= 1'b0;
    end else begin
      evt.start <= scl_s_r[1] & sda_d_r & ~sda_s_r[1];
      evt.stop <= scl_s_r[1] & ~sda_d_r & sda_s_r[1];
      evt.byte_vld <= 1'b0;
      if (scl_s_r[1] & sda_d_r & ~sda_s_r[1]) begin
        cnt_r <= 4'h0;
        first_r <= 1'b1;
      end else if (scl_rise) begin
        if (cnt_r == 4'h8) begin
          cnt_r <= 4'h0;
          first_r <= 1'b0;
        end else begin
          sh_r <= {sh_r[6:0], sda_s_r[1]};
          cnt_r <= cnt_r + 4'h1;
          if (cnt_r == 4'h7) begin
            evt.byte_vld <= 1'b1;
            evt.first <= first_r;
            evt.byte_val <= {sh_r[6:0], sda_s_r[1]};
          end
        end
      end
    end
  end
endmodule : icc_watch

// [core/icc_match.sv]
// Own-address matcher for the target role, 7- or 10-bit.
// Assumes line events from icc_watch on the same clock.
`timescale 1ns/1ps
`include "icc_map.svh"
module icc_match (
  input wire logic CLK, // Bus clock
  input wire logic RST, // Sync reset, high
  input icc_pkg::icc_evt_t evt, // Line events
  input wire logic en, // Target role enabled
  input wire logic wide, // 10-bit target addressing
  input wire logic [9:0] sar, // Own address
  output logic hit // Own address matched in this transfer
);
  import icc_pkg::*;
  icc_mst_t st_r;
  logic [1:0] hi_r;

  assign hit = (st_r == ICC_M_HIT);

  always_ff @(posedge CLK) begin
    if (RST) begin
      st_r <= ICC_M_IDLE;
      hi_r <= 2'h0;
    end else if (evt.start | evt.stop | ~en) begin
      st_r <= ICC_M_IDLE;
    end else if (evt.byte_vld) begin
      case (st_r)
        ICC_M_IDLE: begin
          if (!evt.first) begin
            st_r <= ICC_M_SKIP;
          end else if (evt.byte_val[7:3] == `ICC_WIDE_PFX) begin
            // Wide prefix is never a 7-bit address
            hi_r <= evt.byte_val[2:1];
            st_r <= wide ? ICC_M_WAIT2 : ICC_M_SKIP;
          end else if (!wide && evt.byte_val != `ICC_GCALL
                       && evt.byte_val[7:1] == sar[6:0]) begin
            st_r <= ICC_M_HIT;
          end else begin
            // General call lands here: never an own-address hit
            st_r <= ICC_M_SKIP;
          end
        end
        ICC_M_WAIT2: begin
          st_r <= ({hi_r, evt.byte_val} == sar) ? ICC_M_HIT : ICC_M_SKIP;
        end
        default: begin
          st_r <= st_r;
        end
      endcase
    end
  end
endmodule : icc_match

// [core/icc_top.sv]
// Controller configuration register with APB slave, own-address match and stop qualification.
// Assumes an APB master on CLK and open-drain two-wire lines resolved outside.
//
// Notes on behaviour
// - Config writes are ignored while the controller enable bit reads one.
// - Config bits 10, 11, 16, 17, 18, 19 are read-only.
// - Bit 10 reads zero: master stop interrupt only when master active.
// - Bit 8 picks default or controlled transmit-empty interrupt, reset zero.
// - Bit 7 set: target stop interrupt only when addressed; reset zero.
// - General call never qualifies the addressed-only stop interrupt.
// - Bit 6 disables the target role, reset one.
// - Bit 5 allows repeated starts, reset one.
// - Without repeated starts: no start byte, high speed, turnaround, wide read.
// - Without repeated starts transfers split by stop plus fresh start.
// - A forbidden request without repeated starts sets the abort flag, bit 6.
// - Bit 4 selects 7- or 10-bit master addressing, reset zero.
// - Bit 3 clear: ignore wide transfers, match low 7 address bits.
// - Bit 3 set: answer only wide transfers matching all 10 bits.
// - Bit 0 enables the master, reset one.
// - Bits 2:1 select speed, reset two.
// - Illegal speed writes store the top supported speed.
`timescale 1ns/1ps
`include "icc_map.svh"
module icc_top (
  input wire logic CLK, // Bus clock, 200 MHz
  input wire logic RST, // Sync reset, high
  input wire logic PSEL, // APB select
  input wire logic PENABLE, // APB access phase
  input wire logic PWRITE, // APB direction
  input wire logic [7:0] PADDR, // APB byte address
  input wire logic [31:0] PWDATA, // APB write data
  output logic [31:0] PRDATA, // APB read data
  output logic PREADY, // APB ready
  output logic PSLVERR, // APB error on unmapped address
  input wire logic SCL_I, // Clock line level
  output logic SCL_O, // Clock line drive value
  output logic SCL_OE, // Clock line drive enable
  input wire logic SDA_I, // Data line level
  input wire logic RX_FULL, // Receive buffer physically full
  output logic TARGET_HIT, // Own address matched
  output logic SPLIT_XFER, // Split by stop and start
  output logic CTRL_WIDE, // Master uses 10-bit address
  output logic TXE_CTRL, // Controlled transmit-empty mode
  output logic [1:0] SPEED, // Speed mode
  output logic MASTER_EN, // Master role enabled
  output logic TARGET_EN // Target role enabled
);
  import icc_pkg::*;

  // --------------------------------
  // State
  // --------------------------------
  icc_cfg_t cfg_r;
  icc_cfg_t cfg_nxt;
  icc_evt_t evt;
  logic enable_r;
  logic [9:0] sar_r;
  logic abrt_r;
  logic stop_irq_r;
  logic mst_act_r;
  logic hit;
  logic acc;
  logic wr_go;
  logic rd_go;
  logic mapped;
  logic bad_cmd;
  logic stop_set;
  logic [31:0] rd_val;

  // Speed value legalised on write
  function automatic logic [1:0] fix_speed(input logic [1:0] s);
    if (s == 2'h0 || s > `ICC_TOP_RATE) begin
      fix_speed = `ICC_TOP_RATE;
    end else begin
      fix_speed = s;
    end
  endfunction : fix_speed

  // Register image of the config fields
  function automatic logic [31:0] con_word(input icc_cfg_t c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`ICC_CON_MASTER] = c.master;
    w[`ICC_CON_SPD_HI:`ICC_CON_SPD_LO] = c.speed;
    w[`ICC_CON_TWIDE] = c.twide;
    w[`ICC_CON_CWIDE] = c.cwide;
    w[`ICC_CON_RESTART] = c.restart;
    w[`ICC_CON_TOFF] = c.toff;
    w[`ICC_CON_STOPADDR] = c.stopaddr;
    w[`ICC_CON_TXEC] = c.txec;
    w[`ICC_CON_RXHOLD] = c.rxhold;
    con_word = w;
  endfunction : con_word

  // --------------------------------
  // APB slave, one wait state so read data comes from a flop
  // --------------------------------
  assign acc = PSEL & PENABLE;
  assign wr_go = acc & PREADY & PWRITE;
  assign rd_go = acc & PREADY & ~PWRITE;

  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    if (PADDR == `ICC_OFF_CON) begin
      rd_val = con_word(cfg_r);
    end else if (PADDR == `ICC_OFF_SAR) begin
      rd_val = {22'h0, sar_r};
    end else if (PADDR == `ICC_OFF_MCMD) begin
      rd_val = {31'h0, mst_act_r};
    end else if (PADDR == `ICC_OFF_RAW) begin
      rd_val[`ICC_RAW_ABRT] = abrt_r;
      rd_val[`ICC_RAW_STOP] = stop_irq_r;
    end else if (PADDR == `ICC_OFF_CLR_ABRT) begin
      rd_val = {31'h0, abrt_r};
    end else if (PADDR == `ICC_OFF_CLR_STOP) begin
      rd_val = {31'h0, stop_irq_r};
    end else if (PADDR == `ICC_OFF_ENABLE) begin
      rd_val = {31'h0, enable_r};
    end else begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= acc & ~PREADY;
      if (acc & ~PREADY) begin
        PRDATA <= PWRITE ? 32'h0000_0000 : rd_val;
        PSLVERR <= ~mapped;
      end else begin
        PSLVERR <= 1'b0;
      end
    end
  end

  // --------------------------------
  // Config register
  // --------------------------------
  always_comb begin
    cfg_nxt = cfg_r;
    // Bits 31:10 have no storage, so they stay read-only and zero
    cfg_nxt.master = PWDATA[`ICC_CON_MASTER];
    cfg_nxt.speed = fix_speed(PWDATA[`ICC_CON_SPD_HI:`ICC_CON_SPD_LO]);
    cfg_nxt.twide = PWDATA[`ICC_CON_TWIDE];
    cfg_nxt.cwide = PWDATA[`ICC_CON_CWIDE];
    cfg_nxt.restart = PWDATA[`ICC_CON_RESTART];
    cfg_nxt.toff = PWDATA[`ICC_CON_TOFF];
    cfg_nxt.stopaddr = PWDATA[`ICC_CON_STOPADDR];
    cfg_nxt.txec = PWDATA[`ICC_CON_TXEC];
    cfg_nxt.rxhold = PWDATA[`ICC_CON_RXHOLD];
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      cfg_r <= icc_cfg_t'(10'(`ICC_CON_RST));
    end else if (wr_go && PADDR == `ICC_OFF_CON && !enable_r) begin
      cfg_r <= cfg_nxt;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      enable_r <= 1'b0;
    end else if (wr_go && PADDR == `ICC_OFF_ENABLE) begin
      enable_r <= PWDATA[0];
    end
  end

  // Own address shares the config lock
  always_ff @(posedge CLK) begin
    if (RST) begin
      sar_r <= `ICC_SAR_RST;
    end else if (wr_go && PADDR == `ICC_OFF_SAR && !enable_r) begin
      sar_r <= PWDATA[9:0];
    end
  end

  // --------------------------------
  // Master request screening
  // --------------------------------
  assign bad_cmd = ~cfg_r.restart & (PWDATA[`ICC_CMD_SBYTE] | PWDATA[`ICC_CMD_HS]
                 | PWDATA[`ICC_CMD_DIRCHG]
                 | (PWDATA[`ICC_CMD_RD] & cfg_r.cwide));

  always_ff @(posedge CLK) begin
    if (RST) begin
      abrt_r <= 1'b0;
      mst_act_r <= 1'b0;
    end else begin
      if (wr_go && PADDR == `ICC_OFF_MCMD && enable_r && cfg_r.master && bad_cmd) begin
        abrt_r <= 1'b1;
      end else if (rd_go && PADDR == `ICC_OFF_CLR_ABRT) begin
        abrt_r <= 1'b0;
      end
      if (wr_go && PADDR == `ICC_OFF_MCMD && enable_r && cfg_r.master && !bad_cmd) begin
        mst_act_r <= 1'b1;
      end else if (evt.stop || !enable_r) begin
        mst_act_r <= 1'b0;
      end
    end
  end

  // --------------------------------
  // Line side
  // --------------------------------
  icc_watch u_watch (
    .CLK(CLK),
    .RST(RST),
    .scl_i(SCL_I),
    .sda_i(SDA_I),
    .evt(evt)
  );

  icc_match u_match (
    .CLK(CLK),
    .RST(RST),
    .evt(evt),
    .en(enable_r & ~cfg_r.toff),
    .wide(cfg_r.twide),
    .sar(sar_r),
    .hit(hit)
  );

  // Master stop only while active; target stop needs enable and target role on, plus address match when bit 7 is set
  assign stop_set = evt.stop & (mst_act_r
                  | (enable_r & ~cfg_r.toff & (~cfg_r.stopaddr | hit)));

  always_ff @(posedge CLK) begin
    if (RST) begin
      stop_irq_r <= 1'b0;
    end else if (stop_set) begin
      stop_irq_r <= 1'b1;
    end else if (rd_go && PADDR == `ICC_OFF_CLR_STOP) begin
      stop_irq_r <= 1'b0;
    end
  end

  // --------------------------------
  // Outputs, all from flops
  // --------------------------------
  always_ff @(posedge CLK) begin
    if (RST) begin
      SCL_O <= 1'b0;
      SCL_OE <= 1'b0;
      TARGET_HIT <= 1'b0;
      SPLIT_XFER <= 1'b0;
      TARGET_EN <= 1'b0;
    end else begin
      SCL_O <= 1'b0;
      // Without hold the data path overflows instead of stretching the clock
      SCL_OE <= enable_r & cfg_r.rxhold & RX_FULL;
      TARGET_HIT <= hit;
      SPLIT_XFER <= ~cfg_r.restart;
      TARGET_EN <= ~cfg_r.toff;
    end
  end

  assign CTRL_WIDE = cfg_r.cwide;
  assign TXE_CTRL = cfg_r.txec;
  assign SPEED = cfg_r.speed;
  assign MASTER_EN = cfg_r.master;

  // --------------------------------
  // Checks
  // --------------------------------
  AST_LOCK: assert property (@(posedge CLK) disable iff (RST)
    enable_r && $past(enable_r) |-> $stable(cfg_r))
    else $error("config changed while enabled");

  AST_RO_ZERO: assert property (@(posedge CLK) disable iff (RST)
    rd_go && PADDR == `ICC_OFF_CON |-> PRDATA[31:10] == 22'h0)
    else $error("read-only config bits not zero");

  AST_SPEED: assert property (@(posedge CLK) disable iff (RST)
    cfg_r.speed != 2'h0 && cfg_r.speed <= `ICC_TOP_RATE)
    else $error("illegal speed stored");

  AST_ABORT: assert property (@(posedge CLK) disable iff (RST)
    wr_go && PADDR == `ICC_OFF_MCMD && enable_r && cfg_r.master && bad_cmd && !mst_act_r
    |=> abrt_r && !mst_act_r)
    else $error("forbidden request not aborted");

  AST_STOP_ADDR: assert property (@(posedge CLK) disable iff (RST)
    evt.stop && !mst_act_r && cfg_r.stopaddr && !hit && !stop_irq_r |=> !stop_irq_r)
    else $error("stop flagged without own address");

  AST_STOP_ANY: assert property (@(posedge CLK) disable iff (RST)
    evt.stop && enable_r && !cfg_r.toff && !cfg_r.stopaddr |=> stop_irq_r)
    else $error("stop not flagged");

  AST_HOLD: assert property (@(posedge CLK) disable iff (RST)
    enable_r && cfg_r.rxhold && RX_FULL ##1 enable_r && RX_FULL |-> SCL_OE && !SCL_O)
    else $error("clock line not held on full buffer");

  AST_NO_HOLD: assert property (@(posedge CLK) disable iff (RST)
    !cfg_r.rxhold && $past(!cfg_r.rxhold) |-> !SCL_OE)
    else $error("clock line held with hold policy off");

  AST_TOFF: assert property (@(posedge CLK) disable iff (RST)
    cfg_r.toff && $past(cfg_r.toff) |-> !hit)
    else $error("target matched while disabled");

  AST_SPLIT: assert property (@(posedge CLK) disable iff (RST)
    !cfg_r.restart ##1 !cfg_r.restart |-> SPLIT_XFER)
    else $error("split mode not shown");

  AST_READY: assert property (@(posedge CLK) disable iff (RST)
    acc && !PREADY |=> PREADY ##1 !PREADY)
    else $error("APB answer timing broken");

  AST_TEN: assert property (@(posedge CLK) disable iff (RST)
    $past(cfg_r.toff) |-> !TARGET_EN)
    else $error("target role shown while disabled");

  AST_MSTOP: assert property (@(posedge CLK) disable iff (RST)
    evt.stop && mst_act_r |=> stop_irq_r)
    else $error("master stop not flagged");

  AST_RESTART_OK: assert property (@(posedge CLK) disable iff (RST)
    cfg_r.restart && !abrt_r |=> !abrt_r)
    else $error("abort raised with repeated starts allowed");

  // Illegal speed codes must land as the top supported rate, not as written
  AST_SPEED_FIX: assert property (@(posedge CLK) disable iff (RST)
    wr_go && PADDR == `ICC_OFF_CON && !enable_r
    && (PWDATA[`ICC_CON_SPD_HI:`ICC_CON_SPD_LO] == 2'h0
    || PWDATA[`ICC_CON_SPD_HI:`ICC_CON_SPD_LO] > `ICC_TOP_RATE)
    |=> cfg_r.speed == `ICC_TOP_RATE)
    else $error("illegal speed not replaced");
endmodule : icc_top

// [sim/icc_bus_model.sv]
// Two-wire peer model: pulls lines low to make START, bytes and STOP.
// Assumes the bench resolves both lines with pull-ups; the clock stands high between frames.
`timescale 1ns/1ps
module icc_bus_model (
  output logic scl_low, // Pulls clock line low
  output logic sda_low // Pulls data line low
);
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // ---------------------------------------------
  // Line phases, 160 ns per bit
  // ---------------------------------------------
  task start_cond();
    sda_low = 1'b1;
    #40;
    scl_low = 1'b1;
    #40;
  endtask : start_cond
  task one_bit(input logic v);
    sda_low = ~v;
    #40;
    scl_low = 1'b0;
    #80;
    scl_low = 1'b1;
    #40;
  endtask : one_bit
  // Ack slot left released: the block never drives data, so it reads high
  task send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      one_bit(b[i]);
    end
    one_bit(1'b1);
  endtask : send
  task stop_cond();
    sda_low = 1'b1;
    #40;
    scl_low = 1'b0;
    #40;
    sda_low = 1'b0;
    #80;
  endtask : stop_cond
endmodule : icc_bus_model

// [sim/icc_top_test.sv]
// Self-checking bench for the controller config block over APB and the two-wire lines.
// Assumes icc_map.svh on the include path and the peer model in icc_bus_model.sv.
`timescale 1ns/1ps
`include "icc_map.svh"
module icc_top_test;
  import icc_pkg::*;
  logic clk, rst, psel, penable, pwrite, rx_full, pready, pslverr, scl_o, scl_oe;
  logic hit, split, cwide, txec, men, ten, m_scl_low, m_sda_low;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0] speed;
  wire scl_w;
  wire sda_w;
  int n_errors, comparisons, cycles;
  // Pull-ups: a line is low only while some party pulls it
  assign scl_w = ~(m_scl_low | (scl_oe & ~scl_o));
  assign sda_w = ~m_sda_low;
  icc_top icc_top_inst (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SCL_I(scl_w), .SCL_O(scl_o), .SCL_OE(scl_oe), .SDA_I(sda_w), .RX_FULL(rx_full),
    .TARGET_HIT(hit), .SPLIT_XFER(split), .CTRL_WIDE(cwide), .TXE_CTRL(txec), .SPEED(speed),
    .MASTER_EN(men), .TARGET_EN(ten));
  icc_bus_model icc_bus_model_inst (.scl_low(m_scl_low), .sda_low(m_sda_low));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Hang guard, well above the few thousand cycles the tests take
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      print_verdict();
    end
  end
  // ---------------------------------------------
  // Access tasks
  // ---------------------------------------------
  task print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r,
    output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge so the next call never re-assigns the strobes in this time step
    @(posedge clk);
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] exp, input logic eerr);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check($sformatf("read data %h", a), exp, r);
    check($sformatf("error flag %h", a), {31'h0, eerr}, {31'h0, e});
  endtask : rd
  // Lock released first so own address and config both take
  task cfg(input logic [31:0] c, input logic [31:0] s);
    wr(`ICC_OFF_ENABLE, 32'h0);
    wr(`ICC_OFF_SAR, s);
    wr(`ICC_OFF_CON, c);
    wr(`ICC_OFF_ENABLE, 32'h1);
  endtask : cfg
  task frame(input logic [7:0] b0, input logic two, input logic [7:0] b1, input logic eh,
    input logic es);
    logic [31:0] r;
    logic e;
    icc_bus_model_inst.start_cond();
    icc_bus_model_inst.send(b0);
    if (two) icc_bus_model_inst.send(b1);
    check("target hit", {31'h0, eh}, {31'h0, hit});
    icc_bus_model_inst.stop_cond();
    repeat (8) @(posedge clk);
    rd(`ICC_OFF_RAW, es ? 32'h200 : 32'h0, 1'b0);
    apb(1'b0, `ICC_OFF_CLR_STOP, 32'h0, r, e);
  endtask : frame
  // ---------------------------------------------
  // Tests
  // ---------------------------------------------
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rx_full = 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(`ICC_OFF_CON, 32'h65, 1'b0);
    rd(`ICC_OFF_SAR, 32'h55, 1'b0);
    check("role ports", 32'h60, {25'h0, men, speed, ten, split, cwide, txec});
    $display("test reset done");
    wr(`ICC_OFF_CON, 32'hFFFF_FFFF);
    rd(`ICC_OFF_CON, 32'h3FD, 1'b0);
    check("role ports", 32'h63, {25'h0, men, speed, ten, split, cwide, txec});
    wr(`ICC_OFF_CON, 32'h0);
    rd(`ICC_OFF_CON, 32'h4, 1'b0);
    check("split ports", 32'h3, {29'h0, men, ten, split});
    wr(`ICC_OFF_CON, 32'h2);
    rd(`ICC_OFF_CON, 32'h2, 1'b0);
    wr(`ICC_OFF_ENABLE, 32'h1);
    wr(`ICC_OFF_CON, 32'h3FF);
    rd(`ICC_OFF_CON, 32'h2, 1'b0);
    wr(`ICC_OFF_ENABLE, 32'h0);
    rd(8'hFC, 32'h0, 1'b1);
    $display("test register access done");
    cfg(32'h53, 32'h33);
    for (int i = 0; i < 4; i++) begin
      wr(`ICC_OFF_MCMD, 32'h1 << ((i + 1) % 4));
      rd(`ICC_OFF_RAW, 32'h40, 1'b0);
      rd(`ICC_OFF_CLR_ABRT, 32'h1, 1'b0);
      rd(`ICC_OFF_RAW, 32'h0, 1'b0);
    end
    cfg(32'h73, 32'h33);
    wr(`ICC_OFF_MCMD, 32'h1);
    rd(`ICC_OFF_RAW, 32'h0, 1'b0);
    rd(`ICC_OFF_MCMD, 32'h1, 1'b0);
    frame(8'h66, 1'b0, 8'h00, 1'b0, 1'b1);
    $display("test repeated start done");
    cfg(32'h84, 32'h33);
    frame(8'h66, 1'b0, 8'h00, 1'b1, 1'b1);
    frame(8'h00, 1'b0, 8'h00, 1'b0, 1'b0);
    frame(8'h68, 1'b0, 8'h00, 1'b0, 1'b0);
    cfg(32'h84, 32'h0);
    frame(8'h00, 1'b0, 8'h00, 1'b0, 1'b0);
    cfg(32'h04, 32'h33);
    frame(8'h68, 1'b0, 8'h00, 1'b0, 1'b1);
    cfg(32'h8C, 32'h2A5);
    frame(8'hF4, 1'b1, 8'hA5, 1'b1, 1'b1);
    frame(8'h4A, 1'b0, 8'h00, 1'b0, 1'b0);
    cfg(32'h84, 32'h2A5);
    frame(8'h4A, 1'b0, 8'h00, 1'b1, 1'b1);
    frame(8'hF4, 1'b1, 8'hA5, 1'b0, 1'b0);
    cfg(32'hC4, 32'h33);
    frame(8'h66, 1'b0, 8'h00, 1'b0, 1'b0);
    $display("test target match done");
    cfg(32'h204, 32'h33);
    rx_full <= 1'b1;
    repeat (4) @(posedge clk);
    check("clock hold", 32'h2, {30'h0, scl_oe, scl_o});
    rx_full <= 1'b0;
    repeat (4) @(posedge clk);
    check("clock hold", 32'h0, {31'h0, scl_oe});
    cfg(32'h04, 32'h33);
    rx_full <= 1'b1;
    repeat (4) @(posedge clk);
    check("clock hold", 32'h0, {31'h0, scl_oe});
    rx_full <= 1'b0;
    $display("test bus hold done");
    print_verdict();
  end
endmodule : icc_top_test
